// File: hw/ffsm_defs.svh
/*
 * Constants of the frame filter and source matcher: register offsets,
 * field positions, reset values and list layout figures.
 * Included by the package and the design; defines only.
 */
`ifndef FFSM_DEFS_SVH
`define FFSM_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define FFSM_CTRL_OFFSET 12'h000
`define FFSM_STATUS_OFFSET 12'h004
`define FFSM_SHORT_BASE 12'h100
`define FFSM_LONG_BASE 12'h200
`define FFSM_REGION_BYTES 12'h100

// Control register field positions.
`define FFSM_CTRL_ACCEPT_LSB 0
`define FFSM_CTRL_ADJUST_LSB 8
`define FFSM_CTRL_APPEND_BIT 10
`define FFSM_CTRL_ACKRX_BIT 11
`define FFSM_CTRL_WIDTH 12
`define FFSM_CTRL_RESET 12'h000

// Type MSB adjust codes.
`define FFSM_ADJ_KEEP 2'h0
`define FFSM_ADJ_INVERT 2'h1
`define FFSM_ADJ_CLEAR 2'h2
`define FFSM_ADJ_SET 2'h3

// Frame type of an acknowledgment, and the no-match index.
`define FFSM_TYPE_ACK 3'h2
`define FFSM_NO_MATCH 8'hff

// AXI responses.
`define FFSM_RESP_OKAY 2'h0
`define FFSM_RESP_SLVERR 2'h2

// Bits per enable or pending word.
`define FFSM_BITS_PER_WORD 32

`endif

// File: hw/ffsm_pkg.sv
/*
 * Types of the frame filter and source matcher.
 * Assumes ffsm_defs.svh is on the include path.
 */
package ffsm_pkg;
    `include "ffsm_defs.svh"

    // Kind of source address carried by a received frame.
    typedef enum logic [1:0] {
        FFSM_SRC_NONE,
        FFSM_SRC_SHORT,
        FFSM_SRC_LONG
    } ffsm_src_mode_t;

    // Matcher state.
    typedef enum logic {
        FFSM_IDLE,
        FFSM_SCAN
    } ffsm_state_t;

    // Header facts of one received frame, from the receive path.
    typedef struct packed {
        logic [2:0] frame_type;
        logic [5:0] correlation;
        logic checksum_error_flag;
        ffsm_src_mode_t src_mode;
        logic [15:0] short_address_value;
        logic [15:0] network_identifier;
        logic [63:0] long_address;
    } ffsm_rx_t;

    // Verdict for one received frame.
    typedef struct packed {
        logic valid;
        logic [7:0] result_byte;
        logic index_valid;
        logic [7:0] match_index;
        logic match_pending;
    } ffsm_result_t;
endpackage

// File: hw/ffsm_top.sv
/*
 * Frame filter and source matcher: judges each received frame by type,
 * scans the short or long source lists, and forms the result byte.
 * Assumes one 10 MHz clock, a synchronous reset, header facts from the
 * receive path on the same clock, and software on an AXI4-Lite bus.
 */
`timescale 1ns/1ps
`include "ffsm_defs.svh"
module ffsm_top
    import ffsm_pkg::*;
#(
    parameter int SHORT_ENTRY_COUNT = 8,
    parameter int LONG_ENTRY_COUNT = 8
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset,
    // AXI4-Lite write address and data.
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    // AXI4-Lite read.
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // Receive path.
    input wire logic i_rx_valid,
    input wire ffsm_rx_t i_rx,
    output logic o_rx_ready,
    output ffsm_result_t o_result
);
    // Words of enable or pending bits per list, rounded upward.
    localparam int SHORT_K = (SHORT_ENTRY_COUNT + `FFSM_BITS_PER_WORD - 1) / `FFSM_BITS_PER_WORD;
    localparam int LONG_K = (LONG_ENTRY_COUNT + `FFSM_BITS_PER_WORD - 1) / `FFSM_BITS_PER_WORD;
    localparam int SHORT_WORDS = 2 * SHORT_K + SHORT_ENTRY_COUNT;
    localparam int LONG_WORDS = 2 * LONG_K + 2 * LONG_ENTRY_COUNT;

    // Whole state of the block.
    typedef struct packed {
        logic [`FFSM_CTRL_WIDTH-1:0] ctrl;
        logic awready;
        logic wready;
        logic [11:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        ffsm_state_t state;
        logic rx_ready;
        ffsm_rx_t frame;
        logic ignore;
        logic [7:0] idx;
        ffsm_result_t res;
        logic [SHORT_WORDS-1:0][31:0] short_mem;
        logic [LONG_WORDS-1:0][31:0] long_mem;
    } ffsm_core_t;

    ffsm_core_t st;
    ffsm_core_t next_st;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] ffsm_merge(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] strb);
        logic [31:0] merged;
        merged = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merged[8*b +: 8] = new_word[8*b +: 8];
            end
        end
        return merged;
    endfunction

    // Word index of an address inside a list region and within its stored words, or -1 otherwise.
    function automatic int ffsm_word(input logic [11:0] addr, input logic [11:0] base,
                                     input int words);
        int offs;
        offs = int'(addr) - int'(base);
        if (offs >= 0 && offs < int'(`FFSM_REGION_BYTES) && (offs / 4) < words) begin
            return offs / 4;
        end
        return -1;
    endfunction

    // Frame type after the MSB adjustment.
    function automatic logic [2:0] ffsm_adjust(input logic [2:0] ft, input logic [1:0] code);
        logic [2:0] out;
        out = ft;
        case (code)
            `FFSM_ADJ_INVERT: out[2] = ~ft[2];
            `FFSM_ADJ_CLEAR: out[2] = 1'b0;
            `FFSM_ADJ_SET: out[2] = 1'b1;
            default: out[2] = ft[2];
        endcase
        return out;
    endfunction

    // Next state: bus slave, filter decision and list scan.
    always_comb begin
        int wi;
        int ri;
        int ent;
        logic [2:0] ftype;
        logic hit;
        logic last;
        logic en_bit;
        logic pend_bit;
        logic [31:0] ctrl_word;
        next_st = st;
        wi = -1;
        ri = -1;
        ent = int'(st.idx);
        ftype = 3'h0;
        hit = 1'b0;
        last = 1'b0;
        en_bit = 1'b0;
        pend_bit = 1'b0;
        ctrl_word = 32'h00000000;
        next_st.res.valid = 1'b0;

        // Write address and data are taken in either order.
        if (i_s_axi_awvalid && st.awready) begin
            next_st.aw_addr = i_s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (i_s_axi_wvalid && st.wready) begin
            next_st.w_data = i_s_axi_wdata;
            next_st.w_strb = i_s_axi_wstrb;
            next_st.wready = 1'b0;
        end
        // Both halves held: store and answer.
        if (!st.awready && !st.wready && !st.bvalid) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = `FFSM_RESP_OKAY;
            if (st.aw_addr == `FFSM_CTRL_OFFSET) begin
                // Merge the lanes into the full word, then keep the implemented bits.
                ctrl_word = ffsm_merge({20'h00000, st.ctrl}, st.w_data, st.w_strb);
                next_st.ctrl = ctrl_word[`FFSM_CTRL_WIDTH-1:0];
            end else if (st.aw_addr != `FFSM_STATUS_OFFSET) begin
                wi = ffsm_word(st.aw_addr, `FFSM_SHORT_BASE, SHORT_WORDS);
                if (wi >= 0) begin
                    // Enable, pending and entry words of the short list.
                    next_st.short_mem[wi] = ffsm_merge(st.short_mem[wi], st.w_data, st.w_strb);
                end else begin
                    wi = ffsm_word(st.aw_addr, `FFSM_LONG_BASE, LONG_WORDS);
                    if (wi >= 0) begin
                        // Enable, pending and entry words of the long list.
                        next_st.long_mem[wi] = ffsm_merge(st.long_mem[wi], st.w_data,
                                                          st.w_strb);
                    end else begin
                        next_st.bresp = `FFSM_RESP_SLVERR;
                    end
                end
            end
        end
        if (st.bvalid && i_s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // Reads answer one cycle after the address is taken.
        if (i_s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = `FFSM_RESP_OKAY;
            next_st.rdata = 32'h00000000;
            if (i_s_axi_araddr == `FFSM_CTRL_OFFSET) begin
                next_st.rdata = {20'h00000, st.ctrl};
            end else if (i_s_axi_araddr == `FFSM_STATUS_OFFSET) begin
                next_st.rdata = {14'h0000, st.state == FFSM_SCAN, st.res.match_pending,
                                 st.res.match_index, st.res.result_byte};
            end else begin
                ri = ffsm_word(i_s_axi_araddr, `FFSM_SHORT_BASE, SHORT_WORDS);
                if (ri >= 0) begin
                    next_st.rdata = st.short_mem[ri];
                end else begin
                    ri = ffsm_word(i_s_axi_araddr, `FFSM_LONG_BASE, LONG_WORDS);
                    if (ri >= 0) begin
                        next_st.rdata = st.long_mem[ri];
                    end else begin
                        next_st.rresp = `FFSM_RESP_SLVERR;
                    end
                end
            end
        end
        if (st.rvalid && i_s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        // Frame judging and source list scan.
        case (st.state)
            FFSM_IDLE: begin
                if (i_rx_valid) begin
                    ftype = ffsm_adjust(i_rx.frame_type,
                                        st.ctrl[`FFSM_CTRL_ADJUST_LSB +: 2]);
                    // One accept bit per adjusted type.
                    next_st.ignore = ~(st.ctrl[`FFSM_CTRL_ACCEPT_LSB + int'(ftype)]
                        | (ftype == `FFSM_TYPE_ACK && st.ctrl[`FFSM_CTRL_ACKRX_BIT]));
                    next_st.frame = i_rx;
                    next_st.idx = 8'h00;
                    next_st.rx_ready = 1'b0;
                    next_st.state = FFSM_SCAN;
                end
            end
            FFSM_SCAN: begin
                if (st.frame.src_mode == FFSM_SRC_SHORT) begin
                    en_bit = st.short_mem[ent / 32][ent % 32];
                    pend_bit = st.short_mem[SHORT_K + ent / 32][ent % 32];
                    // Bytes 0-1 address, bytes 2-3 network identifier.
                    hit = en_bit && st.short_mem[2 * SHORT_K + ent] ==
                        {st.frame.network_identifier, st.frame.short_address_value};
                    last = ent >= SHORT_ENTRY_COUNT - 1;
                end else if (st.frame.src_mode == FFSM_SRC_LONG) begin
                    en_bit = st.long_mem[ent / 32][ent % 32];
                    pend_bit = st.long_mem[LONG_K + ent / 32][ent % 32];
                    // Eight bytes, low word first.
                    hit = en_bit && {st.long_mem[2 * LONG_K + 2 * ent + 1],
                        st.long_mem[2 * LONG_K + 2 * ent]} == st.frame.long_address;
                    last = ent >= LONG_ENTRY_COUNT - 1;
                end else begin
                    last = 1'b1;
                end
                if (hit || last) begin
                    next_st.res.valid = 1'b1;
                    next_st.res.result_byte = {st.frame.checksum_error_flag, st.ignore,
                                               st.frame.correlation};
                    next_st.res.index_valid = st.ctrl[`FFSM_CTRL_APPEND_BIT];
                    next_st.res.match_index = hit ? st.idx : `FFSM_NO_MATCH;
                    next_st.res.match_pending = hit && pend_bit;
                    next_st.rx_ready = 1'b1;
                    next_st.state = FFSM_IDLE;
                end else begin
                    next_st.idx = st.idx + 8'h01;
                end
            end
            default: begin
                next_st.state = FFSM_IDLE;
                next_st.rx_ready = 1'b1;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st <= '0;
            st.ctrl <= `FFSM_CTRL_RESET;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.rx_ready <= 1'b1;
            st.state <= FFSM_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign o_s_axi_awready = st.awready;
    assign o_s_axi_wready = st.wready;
    assign o_s_axi_bresp = st.bresp;
    assign o_s_axi_bvalid = st.bvalid;
    assign o_s_axi_arready = st.arready;
    assign o_s_axi_rdata = st.rdata;
    assign o_s_axi_rresp = st.rresp;
    assign o_s_axi_rvalid = st.rvalid;
    assign o_rx_ready = st.rx_ready;
    assign o_result = st.res;
endmodule // ffsm_top

// File: tb/ffsm_sva.sv
/* Checker for the ffsm_top ports: read answers and receive verdicts.
 * Assumes one clock, a synchronous active-high reset, and binding to ffsm_top. */
`timescale 1ns/1ps
module ffsm_sva
    import ffsm_pkg::*;
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Register read channel.
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic [31:0] o_s_axi_rdata,
    // Receive path.
    input wire logic i_rx_valid,
    input wire ffsm_rx_t i_rx,
    input wire logic o_rx_ready,
    input wire ffsm_result_t o_result
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    ffsm_rx_t cap;
    // Keeps the header of the frame under judgement for the verdict checks.
    always_ff @(posedge i_core_clk) begin
        if (i_rx_valid && o_rx_ready) begin
            cap <= i_rx;
        end
    end
    sequence rx_take_s;
        i_rx_valid && o_rx_ready;
    endsequence
    sequence verdict_s;
        o_result.valid;
    endsequence
    corr_field_a: assert property (verdict_s |->
        o_result.result_byte[5:0] == cap.correlation)
        else $error("correlation field differs from the taken header");
    crc_flag_a: assert property (verdict_s |->
        o_result.result_byte[7] == cap.checksum_error_flag)
        else $error("checksum flag differs from the taken header");
    none_index_a: assert property (verdict_s ##0 (cap.src_mode == FFSM_SRC_NONE) |->
        o_result.match_index == 8'hff)
        else $error("frame without source gave a match index");
    nomatch_pend_a: assert property (verdict_s ##0 (o_result.match_index == 8'hff) |->
        !o_result.match_pending)
        else $error("pending bit set without a match");
    // A scan of eight entries answers between two and nine cycles after the take.
    verdict_bound_a: assert property (rx_take_s |-> ##[2:9] verdict_s)
        else $error("no verdict within the scan bound");
    none_bound_a: assert property (rx_take_s ##0 (i_rx.src_mode == FFSM_SRC_NONE) |->
        ##2 verdict_s)
        else $error("late verdict for a frame without source");
    busy_hold_a: assert property (rx_take_s |=> !o_rx_ready until o_result.valid)
        else $error("receive ready rose before the verdict");
    verdict_pulse_a: assert property (verdict_s |=> !o_result.valid)
        else $error("verdict valid longer than one cycle");
    result_hold_a: assert property (!o_result.valid && !$past(i_reset) |->
        $stable(o_result.result_byte))
        else $error("result byte changed without a verdict");
    read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read data not offered one cycle after address");
    read_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
        o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped before acceptance");
endmodule // ffsm_sva

bind ffsm_top ffsm_sva u_sva (.*);

// File: tb/ffsm_rx_model.sv
/* Receive path stand-in that offers frame headers to ffsm_top.
 * Assumes the bench pulses i_send only while no header is pending. */
`timescale 1ns/1ps
module ffsm_rx_model
    import ffsm_pkg::*;
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Bench request.
    input wire logic i_send,
    input wire ffsm_rx_t i_frame,
    // Design side.
    input wire logic i_rx_ready,
    output logic o_rx_valid,
    output ffsm_rx_t o_rx
);
    // Holds a header until taken, then inverts the released lines so stale data never matches.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_rx_valid <= 1'b0;
            o_rx <= '0;
        end else if (i_send) begin
            o_rx_valid <= 1'b1;
            o_rx <= i_frame;
        end else if (o_rx_valid && i_rx_ready) begin
            o_rx_valid <= 1'b0;
            o_rx <= ~o_rx;
        end
    end
endmodule // ffsm_rx_model

// File: tb/ffsm_top_tb.sv
/* Self-checking bench for ffsm_top with random headers and list contents.
 * Assumes ffsm_pkg, ffsm_rx_model and the bound ffsm_sva checker. */
`timescale 1ns/1ps
module ffsm_top_tb
    import ffsm_pkg::*;
;
    logic clk, rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, rxv, rxr, send;
    logic [11:0] awa, ara, ctrl;
    logic [31:0] wd, rd;
    logic [1:0] bresp, rresp;
    logic [63:0] ent[2][8];
    logic [7:0] en[2], pend[2];
    ffsm_rx_t rx, frame;
    ffsm_result_t res;
    int err_count, checks;
    ffsm_top uut (.i_core_clk(clk), .i_reset(rst), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
        .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
        .o_s_axi_wready(wr), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
        .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .i_rx_valid(rxv),
        .i_rx(rx), .o_rx_ready(rxr), .o_result(res));
    ffsm_rx_model u_src (.i_core_clk(clk), .i_reset(rst), .i_send(send), .i_frame(frame),
        .i_rx_ready(rxr), .o_rx_valid(rxv), .o_rx(rx));
    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Waits for the response however long it takes; only the watchdog ends a hang.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!(bv && br));
        r = bresp;
        br <= 1'b0;
    endtask
    // Read data is taken at the edge where rvalid is seen with rready held high.
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!(rv && rr));
        d = rd;
        r = rresp;
        rr <= 1'b0;
    endtask
    // Ignore flag from the adjusted type, the accept bits and the acknowledgment mode.
    function automatic logic exp_ignore(input logic [2:0] t);
        logic [2:0] a;
        a = t;
        a[2] = ctrl[9] ? ctrl[8] : (t[2] ^ ctrl[8]);
        return !(ctrl[a] || (a == 3'h2 && ctrl[11]));
    endfunction
    task automatic load_list(input int l);
        logic [11:0] b;
        logic [31:0] d;
        logic [1:0] r;
        b = l ? 12'h200 : 12'h100;
        en[l] = 8'($urandom);
        pend[l] = 8'($urandom);
        for (int i = 0; i < 8; i++) begin
            ent[l][i] = {$urandom, $urandom};
            if (l == 0) ent[l][i][63:32] = '0;
            if (i == 5) ent[l][i] = ent[l][2];
            axi_wr(b + 12'(4 * (2 + (l + 1) * i)), ent[l][i][31:0], r);
            if (l == 1) axi_wr(b + 12'(4 * (3 + 2 * i)), ent[l][i][63:32], r);
        end
        axi_wr(b, {24'h0, en[l]}, r);
        axi_wr(b + 12'h4, {24'h0, pend[l]}, r);
        axi_rd(b, d, r);
        check({32'h0, 24'h0, en[l]}, {30'h0, r, d});
        axi_rd(b + 12'h4, d, r);
        check({32'h0, 24'h0, pend[l]}, {30'h0, r, d});
    endtask
    task automatic send_check(input ffsm_rx_t f);
        int n;
        int l;
        logic [7:0] idx;
        logic [63:0] key;
        logic [18:0] exp_v;
        l = int'(f.src_mode == FFSM_SRC_LONG);
        key = l ? f.long_address : {32'h0, f.network_identifier, f.short_address_value};
        idx = 8'hff;
        for (int i = 7; i >= 0; i--) begin
            if (f.src_mode != FFSM_SRC_NONE && en[l][i] && ent[l][i] === key) idx = 8'(i);
        end
        @(posedge clk);
        send <= 1'b1;
        frame <= f;
        @(posedge clk);
        send <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (res.valid !== 1'b1 && n < 20);
        // Expected verdict in the field order of the result struct.
        exp_v = {1'b1, f.checksum_error_flag, exp_ignore(f.frame_type), f.correlation,
                 ctrl[10], idx, idx != 8'hff && pend[l][idx[2:0]]};
        check(exp_v, res);
    endtask
    // Watchdog well beyond the expected run of under two thousand cycles.
    initial begin
        #(100 * 30000);
        err_count++;
        report_and_stop();
    end
    // Main sequence: registers, type filtering, then both source lists.
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] acc;
        ffsm_rx_t f;
        void'($urandom(32'h6429));
        {awv, wv, br, arv, rr, send} = '0;
        {awa, ara, wd, ctrl} = '0;
        frame = '0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        axi_rd(12'h000, d, r);
        check(64'h0, {30'h0, r, d});
        axi_wr(12'h000, 32'hffffffff, r);
        axi_rd(12'h000, d, r);
        check(64'h0fff, {30'h0, r, d});
        axi_wr(12'h0f0, 32'h1, r);
        check(64'h2, {62'h0, r});
        axi_rd(12'h0f0, d, r);
        check(64'h2_0000_0000, {30'h0, r, d});
        acc = 8'($urandom);
        for (int rep = 0; rep < 2; rep++) begin
            for (int k = 0; k < 32; k++) begin
                ctrl = {2'($urandom), k[1:0], rep ? ~acc : acc};
                axi_wr(12'h000, {20'h0, ctrl}, r);
                f = $bits(ffsm_rx_t)'({$urandom, $urandom, $urandom, $urandom});
                f.frame_type = k[4:2];
                f.src_mode = FFSM_SRC_NONE;
                send_check(f);
            end
        end
        for (int l = 0; l < 2; l++) begin
            load_list(l);
            for (int k = 0; k < 24; k++) begin
                f = $bits(ffsm_rx_t)'({$urandom, $urandom, $urandom, $urandom});
                f.src_mode = l ? FFSM_SRC_LONG : FFSM_SRC_SHORT;
                if (k % 3 != 0 && l == 1) f.long_address = ent[1][k % 8];
                if (k % 3 != 0 && l == 0)
                    {f.network_identifier, f.short_address_value} = ent[0][k % 8][31:0];
                send_check(f);
            end
        end
        report_and_stop();
    end
endmodule // ffsm_top_tb
